// [hw/ees_pkg.sv]
// Purpose: Shared constants, types and helpers of the SPI EEPROM core
// Assumes: 10 MHz system clock, SPI mode 0 link sampled by that clock
// Notes: Opcode bit 3 is a don't-care; upper nibble must be zero
package ees_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 7;
    localparam int PAGE_BYTES = 128;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = PAGE_W + DATA_W;

    // Opcode fields
    localparam logic [3:0] OP_HI_NIB = 4'h0;
    localparam logic [2:0] OP_SET_LATCH = 3'h6;
    localparam logic [2:0] OP_CLR_LATCH = 3'h4;
    localparam logic [2:0] OP_SR_READ = 3'h5;
    localparam logic [2:0] OP_SR_WRITE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h3;
    localparam logic [2:0] OP_WRITE = 3'h2;

    // Status byte layout
    localparam int SR_PPE_BIT = 7;
    localparam int SR_BP_HI_BIT = 3;
    localparam int SR_BP_LO_BIT = 2;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_BUSY_BIT = 0;
    localparam logic [7:0] SR_BUSY_VALUE = 8'hff;
    localparam logic [7:0] SR_IDLE_FILL = 8'h00;

    // Protect levels and lower bounds of protected ranges
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [15:0] PROT_Q_BASE = 16'hc000;
    localparam logic [15:0] PROT_H_BASE = 16'h8000;
    localparam logic [15:0] PROT_ALL_BASE = 16'h0000;

    // Synchroniser power-up values and bit counter ends
    localparam logic [2:0] SYNC_HI = 3'h7;
    localparam logic [2:0] SYNC_LO = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // Self-timed write cycle
    localparam int T_WC_US = 5000;
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int WC_CYC = T_WC_US * (SYS_CLK_HZ / 1_000_000);

    typedef enum logic [2:0] {
        CMD_NONE, CMD_SET, CMD_CLR, CMD_SRRD, CMD_SRWR, CMD_RD, CMD_WR
    } ees_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OP, ST_ADDR, ST_RD, ST_SR_OUT, ST_WR, ST_SR_IN, ST_IGNORE
    } ees_state_t;

    function automatic ees_cmd_t decode_op(input logic [7:0] op);
        if (op[7:4] != OP_HI_NIB) return CMD_NONE;
        case (op[2:0])
            OP_SET_LATCH: return CMD_SET;
            OP_CLR_LATCH: return CMD_CLR;
            OP_SR_READ: return CMD_SRRD;
            OP_SR_WRITE: return CMD_SRWR;
            OP_READ: return CMD_RD;
            OP_WRITE: return CMD_WR;
            default: return CMD_NONE;
        endcase
    endfunction

    function automatic logic addr_protected(input logic [15:0] a,
                                            input logic [1:0] bp);
        case (bp)
            BP_NONE: return 1'b0;
            BP_QUARTER: return a >= PROT_Q_BASE;
            BP_HALF: return a >= PROT_H_BASE;
            default: return a >= PROT_ALL_BASE;
        endcase
    endfunction

endpackage

// [hw/ees_fifo.sv]
// Purpose: Small synchronous FIFO between byte receiver and page buffer
// Assumes: Single clock, synchronous active-high reset
// Notes: Extra pointer bit tells full from empty
`timescale 1ns/1ps
module ees_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_r [0:DEPTH-1];
    logic [PW:0] wr_ptr_r;
    logic [PW:0] rd_ptr_r;
    logic [PW:0] fill;

    assign fill = wr_ptr_r - rd_ptr_r;
    assign in_ready = (fill != (PW+1)'(DEPTH));
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data = buf_r[rd_ptr_r[PW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (in_valid && in_ready) begin
            buf_r[wr_ptr_r[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_r <= '0;
        end else if (in_valid && in_ready) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_ptr_r <= '0;
        end else if (out_valid && out_ready) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule // ees_fifo

// [hw/ees_spi_eeprom.sv]
// Purpose: Command, protection and array logic of a 64 KiB SPI EEPROM
// Assumes: SPI mode 0; link pins sampled by sys_clk, SCK well below it
// Notes: reset stands for power-up; array content is never reset
//
// What this block does
// - Protect level picks range: none, C000h up, 8000h up, or everything.
// - Writes into the protected range leave those bytes unchanged.
// - Protect bits need latch, take a timed cycle, polled via status read.
// - Hardware protection active only when pin low and pin enable set.
// - Pin high or enable clear: status writes depend on latch alone.
// - Hardware protection rejects status writes; unprotected array writes pass.
// - Pin enable cannot be cleared while pin low and bit set.
// - Read: opcode, 16-bit address, then data out MSB first, input ignored.
// - Reads auto-increment and wrap from top address to zero.
// - Master sends set-latch as its own transaction before a write.
// - During programming only the status read is obeyed.
// - Write is opcode, address, data; programming starts at select rise.
// - Status bit 0 reads one while busy, zero when done.
// - Page write increments only the seven low address bits.
// - Over 128 bytes wraps within the page, overwriting earlier bytes.
// - Latch clears automatically when programming completes.
// - Write without latch is discarded until next select fall.
// - Opcodes: upper nibble zero, bit 3 ignored, six command codes.
// - Status: enable bit 7, level bits 3:2, latch 1, busy 0.
// - Latch is clear after power-up.
// - Unknown opcode: ignore input, output off until next select fall.
`timescale 1ns/1ps
module ees_spi_eeprom #(
    parameter int WC_CYCLES = ees_pkg::WC_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic prog_busy,
    output logic write_latch,
    output logic hw_protect
);
    localparam int TMR_W = $clog2(WC_CYCLES + 1);

    // Nonvolatile array and page staging buffer
    logic [7:0] mem [0:65535];
    logic [7:0] pg_data [0:ees_pkg::PAGE_BYTES-1];
    logic [ees_pkg::PAGE_BYTES-1:0] pg_valid_r;

    // Pin synchronisers: stage 0 feeds stage 1 only
    logic [2:0] cs_sy_r;
    logic [2:0] sck_sy_r;
    logic [2:0] si_sy_r;
    logic [2:0] wp_sy_r;
    logic cs_f_r;
    logic sck_f_r;
    logic si_f_r;
    logic wp_f_r;
    logic cs_q_r;
    logic sck_q_r;

    ees_pkg::ees_state_t state_r;
    ees_pkg::ees_cmd_t cmd_r;
    ees_pkg::ees_cmd_t rx_cmd;
    logic [2:0] bitcnt_r;
    logic [7:0] shift_in_r;
    logic [7:0] shift_out_r;
    logic [15:0] addr_r;
    logic addr_hi_done_r;
    logic data_seen_r;
    logic drop_r;
    logic [7:0] sr_new_r;
    logic [1:0] bp_r;
    logic ppe_r;
    logic commit_pend_r;
    logic commit_sr_r;
    logic prog_sr_r;
    logic [8:0] page_r;
    logic [ees_pkg::PAGE_W:0] prog_idx_r;
    logic [TMR_W-1:0] timer_r;

    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [7:0] status_byte;
    logic [15:0] prog_addr;
    logic push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ees_pkg::FIFO_W-1:0] fifo_out_data;
    logic wr_go;
    logic sr_go;
    logic prog_start;
    logic prog_end;

    // Three-stage sampling; a level is taken once stages 1 and 2 agree
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cs_sy_r <= ees_pkg::SYNC_HI;
            sck_sy_r <= ees_pkg::SYNC_LO;
            si_sy_r <= ees_pkg::SYNC_LO;
            wp_sy_r <= ees_pkg::SYNC_HI;
        end else begin
            cs_sy_r <= {cs_sy_r[1:0], cs_n};
            sck_sy_r <= {sck_sy_r[1:0], sck};
            si_sy_r <= {si_sy_r[1:0], si};
            wp_sy_r <= {wp_sy_r[1:0], wp_n};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cs_f_r <= 1'b1;
            sck_f_r <= 1'b0;
            si_f_r <= 1'b0;
            wp_f_r <= 1'b1;
        end else begin
            if (cs_sy_r[1] == cs_sy_r[2]) cs_f_r <= cs_sy_r[2];
            if (sck_sy_r[1] == sck_sy_r[2]) sck_f_r <= sck_sy_r[2];
            if (si_sy_r[1] == si_sy_r[2]) si_f_r <= si_sy_r[2];
            if (wp_sy_r[1] == wp_sy_r[2]) wp_f_r <= wp_sy_r[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cs_q_r <= 1'b1;
            sck_q_r <= 1'b0;
        end else begin
            cs_q_r <= cs_f_r;
            sck_q_r <= sck_f_r;
        end
    end

    assign cs_fall = cs_q_r && !cs_f_r;
    assign cs_rise = !cs_q_r && cs_f_r;
    assign sck_rise = !cs_f_r && !sck_q_r && sck_f_r;
    assign sck_fall = !cs_f_r && sck_q_r && !sck_f_r;
    assign byte_done = sck_rise && (bitcnt_r == ees_pkg::BIT_LAST);
    assign rx_byte = {shift_in_r[6:0], si_f_r};
    assign rx_cmd = ees_pkg::decode_op(rx_byte);

    // Status byte; all ones while busy
    always_comb begin
        status_byte = ees_pkg::SR_IDLE_FILL;
        status_byte[ees_pkg::SR_PPE_BIT] = ppe_r;
        status_byte[ees_pkg::SR_BP_HI_BIT] = bp_r[1];
        status_byte[ees_pkg::SR_BP_LO_BIT] = bp_r[0];
        status_byte[ees_pkg::SR_WEL_BIT] = write_latch;
        status_byte[ees_pkg::SR_BUSY_BIT] = 1'b0;
        if (prog_busy) status_byte = ees_pkg::SR_BUSY_VALUE;
    end

    // Input shifter, sampled on SCK rise
    always_ff @(posedge sys_clk) begin
        if (reset || cs_fall) begin
            bitcnt_r <= ees_pkg::BIT_FIRST;
            shift_in_r <= '0;
        end else if (sck_rise) begin
            bitcnt_r <= bitcnt_r + 1'b1;
            shift_in_r <= rx_byte;
        end
    end

    // Command sequencer
    always_ff @(posedge sys_clk) begin
        if (reset || cs_f_r) begin
            state_r <= ees_pkg::ST_IDLE;
            cmd_r <= ees_pkg::CMD_NONE;
        end else if (cs_fall) begin
            state_r <= ees_pkg::ST_OP;
        end else if (byte_done) begin
            unique case (state_r)
                ees_pkg::ST_OP: begin
                    cmd_r <= rx_cmd;
                    if (prog_busy && rx_cmd != ees_pkg::CMD_SRRD) begin
                        state_r <= ees_pkg::ST_IGNORE;
                    end else begin
                        unique case (rx_cmd)
                            ees_pkg::CMD_SRRD: state_r <= ees_pkg::ST_SR_OUT;
                            ees_pkg::CMD_RD: state_r <= ees_pkg::ST_ADDR;
                            ees_pkg::CMD_WR:
                                state_r <= write_latch ? ees_pkg::ST_ADDR
                                                       : ees_pkg::ST_IGNORE;
                            ees_pkg::CMD_SRWR:
                                state_r <= write_latch ? ees_pkg::ST_SR_IN
                                                       : ees_pkg::ST_IGNORE;
                            default: state_r <= ees_pkg::ST_IGNORE;
                        endcase
                    end
                end
                ees_pkg::ST_ADDR: begin
                    if (addr_hi_done_r) begin
                        state_r <= (cmd_r == ees_pkg::CMD_RD) ? ees_pkg::ST_RD
                                                              : ees_pkg::ST_WR;
                    end
                end
                ees_pkg::ST_IDLE, ees_pkg::ST_RD, ees_pkg::ST_SR_OUT,
                ees_pkg::ST_WR, ees_pkg::ST_SR_IN, ees_pkg::ST_IGNORE: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Latch: cleared at power-up and after every programming cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            write_latch <= 1'b0;
        end else if (prog_end) begin
            write_latch <= 1'b0;
        end else if (byte_done && state_r == ees_pkg::ST_OP && !prog_busy) begin
            if (rx_cmd == ees_pkg::CMD_SET) write_latch <= 1'b1;
            if (rx_cmd == ees_pkg::CMD_CLR) write_latch <= 1'b0;
        end
    end

    // Address: loaded MSB byte first, then advanced by reads or page writes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_r <= '0;
            addr_hi_done_r <= 1'b0;
        end else if (cs_fall) begin
            addr_hi_done_r <= 1'b0;
        end else if (byte_done && state_r == ees_pkg::ST_ADDR) begin
            addr_r <= {addr_r[7:0], rx_byte};
            addr_hi_done_r <= 1'b1;
        end else if (byte_done && state_r == ees_pkg::ST_WR) begin
            addr_r[6:0] <= addr_r[6:0] + 1'b1;
        end else if (sck_fall && state_r == ees_pkg::ST_RD
                     && bitcnt_r == ees_pkg::BIT_FIRST) begin
            addr_r <= addr_r + 1'b1;
        end
    end

    // Output shifter: new byte at the fall that opens each byte
    always_ff @(posedge sys_clk) begin
        if (reset || cs_f_r) begin
            so <= 1'b0;
            so_oe <= 1'b0;
            shift_out_r <= '0;
        end else if (sck_fall && (state_r == ees_pkg::ST_RD
                                  || state_r == ees_pkg::ST_SR_OUT)) begin
            so_oe <= 1'b1;
            if (bitcnt_r == ees_pkg::BIT_FIRST) begin
                if (state_r == ees_pkg::ST_RD) begin
                    so <= mem[addr_r][7];
                    shift_out_r <= {mem[addr_r][6:0], 1'b0};
                end else begin
                    so <= status_byte[7];
                    shift_out_r <= {status_byte[6:0], 1'b0};
                end
            end else begin
                so <= shift_out_r[7];
                shift_out_r <= {shift_out_r[6:0], 1'b0};
            end
        end else if (state_r == ees_pkg::ST_IGNORE) begin
            so_oe <= 1'b0;
        end
    end

    // Data byte bookkeeping for the commit decision
    assign push = byte_done && state_r == ees_pkg::ST_WR;

    always_ff @(posedge sys_clk) begin
        if (reset || cs_fall) begin
            data_seen_r <= 1'b0;
            drop_r <= 1'b0;
            sr_new_r <= '0;
        end else if (byte_done) begin
            if (state_r == ees_pkg::ST_WR) data_seen_r <= 1'b1;
            if (push && !fifo_in_ready) drop_r <= 1'b1;
            if (state_r == ees_pkg::ST_SR_IN) begin
                data_seen_r <= 1'b1;
                sr_new_r <= rx_byte;
            end
        end
    end

    // Commit only on a clean byte boundary after data
    assign wr_go = cs_rise && state_r == ees_pkg::ST_WR && data_seen_r
                   && !drop_r && bitcnt_r == ees_pkg::BIT_FIRST
                   && write_latch && !prog_busy;
    // Pin protection checked at the select rise
    assign sr_go = cs_rise && state_r == ees_pkg::ST_SR_IN && data_seen_r
                   && bitcnt_r == ees_pkg::BIT_FIRST && write_latch
                   && !prog_busy && !(!wp_f_r && ppe_r);

    // Hardware protection flag
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hw_protect <= 1'b0;
        end else begin
            hw_protect <= !wp_f_r && ppe_r;
        end
    end

    // Commit waits for the FIFO to drain into the page buffer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            commit_pend_r <= 1'b0;
            commit_sr_r <= 1'b0;
        end else if (wr_go || sr_go) begin
            commit_pend_r <= 1'b1;
            commit_sr_r <= sr_go;
        end else if (prog_start) begin
            commit_pend_r <= 1'b0;
        end
    end

    assign prog_start = commit_pend_r && !fifo_out_valid;
    assign prog_end = prog_busy && timer_r == '0;

    ees_fifo #(
        .WIDTH(ees_pkg::FIFO_W),
        .DEPTH(ees_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(push),
        .in_data({addr_r[6:0], rx_byte}),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    // Page buffer; later bytes to one offset replace earlier ones
    always_ff @(posedge sys_clk) begin
        if (fifo_out_valid) begin
            pg_data[fifo_out_data[ees_pkg::FIFO_W-1:ees_pkg::DATA_W]]
                <= fifo_out_data[ees_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pg_valid_r <= '0;
        end else if (byte_done && state_r == ees_pkg::ST_ADDR
                     && addr_hi_done_r) begin
            pg_valid_r <= '0;
        end else if (fifo_out_valid) begin
            pg_valid_r[fifo_out_data[ees_pkg::FIFO_W-1:ees_pkg::DATA_W]]
                <= 1'b1;
        end
    end

    // Self-timed programming cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prog_busy <= 1'b0;
            prog_sr_r <= 1'b0;
            timer_r <= '0;
            page_r <= '0;
        end else if (prog_start) begin
            prog_busy <= 1'b1;
            prog_sr_r <= commit_sr_r;
            timer_r <= TMR_W'(WC_CYCLES - 1);
            page_r <= addr_r[15:7];
        end else if (prog_busy) begin
            timer_r <= timer_r - 1'b1;
            if (prog_end) prog_busy <= 1'b0;
        end
    end

    // Array copy walks the page during the first cycles of the timer
    always_ff @(posedge sys_clk) begin
        if (reset || prog_start) begin
            prog_idx_r <= '0;
        end else if (prog_busy && !prog_idx_r[ees_pkg::PAGE_W]) begin
            prog_idx_r <= prog_idx_r + 1'b1;
        end
    end

    assign prog_addr = {page_r, prog_idx_r[ees_pkg::PAGE_W-1:0]};

    always_ff @(posedge sys_clk) begin
        if (prog_busy && !prog_sr_r && !prog_idx_r[ees_pkg::PAGE_W]
            && pg_valid_r[prog_idx_r[ees_pkg::PAGE_W-1:0]]
            && !ees_pkg::addr_protected(prog_addr, bp_r)) begin
            mem[prog_addr] <= pg_data[prog_idx_r[ees_pkg::PAGE_W-1:0]];
        end
    end

    // Protection bits take their new value at the end of the cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bp_r <= ees_pkg::BP_NONE;
            ppe_r <= 1'b0;
        end else if (prog_end && prog_sr_r) begin
            bp_r <= sr_new_r[ees_pkg::SR_BP_HI_BIT:ees_pkg::SR_BP_LO_BIT];
            ppe_r <= sr_new_r[ees_pkg::SR_PPE_BIT];
        end
    end
endmodule // ees_spi_eeprom

// [tb/ees_spi_master.sv]
// Purpose: SPI mode 0 master model for the EEPROM link
// Assumes: 800 ns SCK, edges 1 ns after a sys_clk rise
// Notes: SCK stands low between frames
`timescale 1ns/1ps
module ees_spi_master (
    input wire logic sys_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    initial begin
        cs_n = 1'h1;
        sck = 1'h0;
        si = 1'h0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Opcode, address, data MSB first
    task automatic frame(input logic [47:0] b, input int nb,
                         output logic [7:0] rx);
        cs_n = 1'h0;
        for (int i = 0; i < nb; i++) begin
            si = b[nb-1-i];
            cyc(4);
            sck = 1'h1;
            cyc(4);
            // Output valid late in the high phase, so take it before fall
            rx = {rx[6:0], so};
            sck = 1'h0;
        end
        cyc(2);
        cs_n = 1'h1; // In SCK low after last D0
        si = ~si;
        cyc(12);
    endtask
endmodule // ees_spi_master

// [tb/ees_spi_eeprom_asserts.sv]
// Purpose: Port checks of the SPI EEPROM core
// Assumes: One clock domain, synchronous active-high reset
// Notes: Busy length allows one cycle of slack
`timescale 1ns/1ps
module ees_spi_eeprom_asserts #(
    parameter int WC_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic prog_busy,
    input wire logic write_latch,
    input wire logic hw_protect
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    int busy_n_r;
    always_ff @(posedge sys_clk) begin
        if (reset || !prog_busy) begin
            busy_n_r <= 0;
        end else begin
            busy_n_r <= busy_n_r + 1;
        end
    end
    a_reset_quiet: assert property ($fell(reset) |->
        !prog_busy && !write_latch && !so_oe) else $error("not quiet");
    a_busy_needs_latch: assert property ($rose(prog_busy) |->
        write_latch && cs_n) else $error("busy without latch");
    a_busy_clears_latch: assert property ($fell(prog_busy) |->
        !write_latch) else $error("latch kept");
    a_busy_length: assert property ($fell(prog_busy) |->
        busy_n_r >= WC_CYCLES && busy_n_r <= WC_CYCLES + 1)
        else $error("busy length");
    a_latch_not_busy: assert property ($rose(write_latch) |->
        !prog_busy) else $error("latch set while busy");
    a_pin_high_free: assert property (wp_n [*8] |->
        !hw_protect) else $error("protect with pin high");
    a_pin_prot_hold: assert property (hw_protect && !wp_n |=>
        hw_protect) else $error("protect dropped");
    a_sel_off_quiet: assert property (cs_n [*8] |->
        !so_oe) else $error("output on while idle");
    a_oe_needs_sel: assert property ($rose(so_oe) |->
        !cs_n) else $error("output on unselected");
endmodule // ees_spi_eeprom_asserts

bind ees_spi_eeprom ees_spi_eeprom_asserts #(.WC_CYCLES(WC_CYCLES))
    i_ees_spi_eeprom_asserts (.sys_clk(sys_clk), .reset(reset),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .prog_busy(prog_busy), .write_latch(write_latch),
    .hw_protect(hw_protect));

// [tb/tb.sv]
// Purpose: Self-checking bench of the SPI EEPROM core
// Assumes: 10 MHz sys_clk, 800 ns SCK from the master model
// Notes: Short write cycle keeps the run brief
`timescale 1ns/1ps
module tb;
    localparam int WC = 600;
    typedef struct packed {
        logic [1:0] lvl;
        logic [15:0] a;
        logic [7:0] d;
        logic wr;
    } ees_row_t;
    ees_row_t rows [6] = '{'{2'h1, 16'hbfff, 8'h11, 1'h1},
        '{2'h1, 16'hc000, 8'h22, 1'h0}, '{2'h2, 16'h7fff, 8'h33, 1'h1},
        '{2'h2, 16'h8000, 8'h44, 1'h0}, '{2'h3, 16'h0000, 8'h55, 1'h0},
        '{2'h0, 16'hffff, 8'h66, 1'h1}};
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic wp_n = 1'h1;
    logic cs_n, sck, si, so, so_oe, prog_busy, write_latch, hw_protect;
    logic [7:0] rx;
    tri1 so_line;
    int errors = 0;
    int checked = 0;
    always #50 sys_clk = ~sys_clk;
    assign so_line = so_oe ? so : 1'hz;
    ees_spi_eeprom #(.WC_CYCLES(WC)) i_ees_spi_eeprom (.sys_clk(sys_clk),
        .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .prog_busy(prog_busy),
        .write_latch(write_latch), .hw_protect(hw_protect));
    ees_spi_master i_ees_spi_master (.sys_clk(sys_clk), .cs_n(cs_n),
        .sck(sck), .si(si), .so(so_line));

    task automatic cyc(input int n);
        i_ees_spi_master.cyc(n);
    endtask
    task automatic run(input logic [47:0] b, input int nb);
        i_ees_spi_master.frame(b, nb, rx);
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic idle;
        for (int i = 0; i < 900 && prog_busy !== 1'h0; i++) begin
            cyc(1);
        end
        // A cycle that never ends counts as a mismatch
        chk("idle", 8'h00, {7'h0, prog_busy});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        run(8'h06, 8); // Latch in its own frame
        run({8'h02, a, d}, 32);
        idle();
    endtask
    task automatic wsr(input logic [7:0] v);
        run(8'h06, 8);
        run({8'h01, v}, 16);
        idle();
    endtask
    task automatic end_sim;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20);
        reset = 1'h0;
        cyc(4);
        // Pass 0 fills known data, pass 1 tries each protect level
        for (int p = 0; p < 2; p++) begin
            foreach (rows[i]) begin
                wsr({4'h0, p ? rows[i].lvl : 2'h0, 2'h0});
                wr(rows[i].a, p ? rows[i].d : 8'ha5);
                run({8'h03, rows[i].a, 8'h00}, 32);
                chk("array", p && rows[i].wr ? rows[i].d : 8'ha5, rx);
            end
        end
        $display("rows done");
        run(8'h0e, 8);
        run(16'h0d00, 16);
        chk("status", 8'h02, rx);
        run(8'h0c, 8);
        run(16'h0500, 16);
        chk("status", 8'h00, rx);
        run(24'h150000, 24);
        chk("bad op", 8'hff, rx);
        run({8'h02, 16'hbfff, 8'h77}, 32);
        chk("busy", 8'h00, {7'h0, prog_busy});
        run({8'h03, 16'hffff, 16'h0}, 40);
        chk("wrap", 8'ha5, rx);
        $display("opcodes done");
        run(8'h06, 8);
        run({8'h02, 16'h7fff, 8'h99}, 32);
        run(16'h0500, 16);
        chk("busy status", 8'hff, rx);
        run(8'h04, 8);
        chk("latch", 8'h01, {7'h0, write_latch});
        run({8'h03, 16'h7fff, 8'h00}, 32);
        chk("busy read", 8'hff, rx);
        idle();
        chk("latch", 8'h00, {7'h0, write_latch});
        run(16'h0500, 16);
        chk("status", 8'h00, rx);
        // Latch and write in one frame must not program
        run({8'h06, 8'h02, 16'h12fe, 8'ha1}, 40);
        chk("one frame", 8'h00, {7'h0, prog_busy});
        run(8'h06, 8);
        run({8'h02, 16'h12fe, 24'ha1b2c3}, 48);
        idle();
        run({8'h03, 16'h1280, 8'h00}, 32);
        chk("page wrap", 8'hc3, rx);
        run(8'h06, 8);
        run({8'h02, 16'hbfff, 4'h1}, 28);
        chk("abort", 8'h00, {7'h0, prog_busy});
        $display("cycles done");
        wsr(8'h80);
        wp_n = 1'h0;
        cyc(8);
        chk("hw prot", 8'h01, {7'h0, hw_protect});
        wsr(8'h00);
        wr(16'h0200, 8'h5a);
        run(16'h0500, 16);
        chk("status", 8'h80, rx & 8'h8c);
        run({8'h03, 16'h0200, 8'h00}, 32);
        chk("array", 8'h5a, rx);
        wp_n = 1'h1;
        cyc(8);
        chk("hw prot", 8'h00, {7'h0, hw_protect});
        wsr(8'h00);
        run(16'h0500, 16);
        chk("status", 8'h00, rx & 8'h8c);
        run(8'h06, 8);
        reset = 1'h1;
        cyc(4);
        reset = 1'h0;
        cyc(1);
        chk("reset", 8'h00, {5'h0, write_latch, prog_busy, hw_protect});
        $display("protect done");
        end_sim();
    end

    initial begin
        #6000000;
        errors++;
        end_sim();
    end
endmodule // tb
